// ===== rtl/dsc_pkg.sv
// package: constants for the serial delay configuration block
package dsc_pkg;
    localparam int WORD_W       = 11;
    localparam int CODE_W       = 9;
    localparam int CHAN_POS     = 0;
    localparam int MODE_POS     = 1;
    localparam int CODE_LSB     = 2;
    localparam int NUM_CHAN     = 2;
    localparam int SYNC_DEPTH   = 3;
    localparam int STEP_PS      = 11;
    localparam int STEP_PS_W    = 14;
    localparam logic [WORD_W-1:0] WORD_RST = 11'h000;
    localparam logic [CODE_W-1:0] CODE_RST = 9'h000;
    localparam logic [1:0] CSR_CODE_A  = 2'h0;
    localparam logic [1:0] CSR_CODE_B  = 2'h1;
    localparam logic [1:0] CSR_MODE    = 2'h2;
    localparam logic [1:0] CSR_SHIFT   = 2'h3;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
    typedef enum logic [1:0] {
        DSC_IDLE  = 2'b00,
        DSC_SHIFT = 2'b01,
        DSC_OPEN  = 2'b10
    } dsc_state_t;
endpackage

// ===== rtl/dsc_top.sv
// serial configuration path of a dual programmable delay device
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dsc_top
    import dsc_pkg::*;
(
    input  wire logic                REF_CLK,
    input  wire logic                RESET_N,
    input  wire logic                SERIAL_CLK,
    input  wire logic                SERIAL_BIT_INPUT,
    input  wire logic                WORD_LOAD_STROBE,
    input  wire logic [1:0]          AVS_ADDRESS,
    input  wire logic                AVS_READ,
    input  wire logic                AVS_WRITE,
    input  wire logic [31:0]         AVS_WRITEDATA,
    output logic      [31:0]         AVS_READDATA,
    output logic                     AVS_WAITREQUEST,
    output logic [dsc_pkg::CODE_W-1:0] DELAY_CHANNEL_A,
    output logic [dsc_pkg::CODE_W-1:0] DELAY_CHANNEL_B,
    output logic                     CASCADE_MODE_BIT,
    output logic                     OUTPUT_A_PARKED,
    output logic [dsc_pkg::STEP_PS_W-1:0] DELAY_PS_A,
    output logic [dsc_pkg::STEP_PS_W-1:0] DELAY_PS_B
);
    import dsc_pkg::*;

    // three-stage synchronisers for the three pins
    logic [SYNC_DEPTH-1:0] sclk_sync_reg;
    logic [SYNC_DEPTH-1:0] sdat_sync_reg;
    logic [SYNC_DEPTH-1:0] sld_sync_reg;
    logic                  sclk_lvl_reg;
    logic                  sld_lvl_reg;
    logic                  sdat_lvl_reg;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sclk_sync_reg <= '0;
            sdat_sync_reg <= '0;
            sld_sync_reg  <= '0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], SERIAL_CLK};
            sdat_sync_reg <= {sdat_sync_reg[1:0], SERIAL_BIT_INPUT};
            sld_sync_reg  <= {sld_sync_reg[1:0], WORD_LOAD_STROBE};
        end
    end

    // a level counts only once stages two and three agree
    wire sclk_agree = sclk_sync_reg[1] == sclk_sync_reg[2];
    wire sdat_agree = sdat_sync_reg[1] == sdat_sync_reg[2];
    wire sld_agree  = sld_sync_reg[1] == sld_sync_reg[2];
    wire sclk_next  = sclk_agree ? sclk_sync_reg[2] : sclk_lvl_reg;
    wire sdat_next  = sdat_agree ? sdat_sync_reg[2] : sdat_lvl_reg;
    wire sld_next   = sld_agree ? sld_sync_reg[2] : sld_lvl_reg;
    wire sclk_rise  = sclk_next & ~sclk_lvl_reg;
    wire sld_fall   = ~sld_next & sld_lvl_reg;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sclk_lvl_reg <= 1'b0;
            sdat_lvl_reg <= 1'b0;
            sld_lvl_reg  <= 1'b0;
        end else begin
            sclk_lvl_reg <= sclk_next;
            sdat_lvl_reg <= sdat_next;
            sld_lvl_reg  <= sld_next;
        end
    end

    // shift register
    // data taken from the agreed level, in the same cycle as the clock edge,
    // which matches the pin's setup window at the 15.625 MHz serial rate
    logic [WORD_W-1:0] shift_reg;
    wire  [WORD_W-1:0] shift_next = {sdat_next, shift_reg[WORD_W-1:1]};

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N)
            shift_reg <= WORD_RST;
        else if (sclk_rise)
            shift_reg <= shift_next;
    end

    // word fields
    // first bit in ends at bit 0 after eleven shifts; last bit is code msb
    wire              word_chan = shift_reg[CHAN_POS];
    wire              word_mode = shift_reg[MODE_POS];
    wire [CODE_W-1:0] word_code = shift_reg[WORD_W-1:CODE_LSB];

    // small sequencer tracking the strobe phases
    dsc_state_t state_reg;
    dsc_state_t state_next;

    always_comb begin
        case (state_reg)
            DSC_IDLE:  state_next = sclk_rise ? DSC_SHIFT : DSC_IDLE;
            DSC_SHIFT: state_next = sld_next ? DSC_OPEN : DSC_SHIFT;
            DSC_OPEN:  state_next = sld_fall ? DSC_IDLE : DSC_OPEN;
            default:   state_next = DSC_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N)
            state_reg <= DSC_IDLE;
        else
            state_reg <= state_next;
    end

    // latch open only while the strobe is high
    wire latch_open = sld_next;

    logic [CODE_W-1:0] code_reg [NUM_CHAN];
    logic              mode_reg;

    // per-channel latch, written only when addressed
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
            // a genvar cannot be bit-selected, so cast it to one bit
            wire hit = latch_open && (word_chan == 1'(ch));
            always_ff @(posedge REF_CLK or negedge RESET_N) begin
                if (!RESET_N)
                    code_reg[ch] <= CODE_RST;
                else if (hit)
                    code_reg[ch] <= word_code;
            end
        end
    endgenerate

    // mode is common to both channels, follows each load
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N)
            mode_reg <= 1'b0;
        else if (latch_open)
            mode_reg <= word_mode;
    end

    // path control and nominal delay
    // total delay in cascade is a plus b, reported on b; fixed path
    // delay is analog and not modelled here
    wire [STEP_PS_W-1:0] ps_a =
        STEP_PS_W'(code_reg[0]) * STEP_PS_W'(STEP_PS);
    wire [STEP_PS_W-1:0] ps_b =
        STEP_PS_W'(code_reg[1]) * STEP_PS_W'(STEP_PS);
    wire [STEP_PS_W-1:0] ps_a_out = mode_reg ? '0 : ps_a;
    wire [STEP_PS_W-1:0] ps_b_out = mode_reg ? STEP_PS_W'(ps_a + ps_b) : ps_b;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DELAY_CHANNEL_A  <= CODE_RST;
            DELAY_CHANNEL_B  <= CODE_RST;
            CASCADE_MODE_BIT <= 1'b0;
            OUTPUT_A_PARKED  <= 1'b0;
            DELAY_PS_A       <= '0;
            DELAY_PS_B       <= '0;
        end else begin
            DELAY_CHANNEL_A  <= code_reg[0];
            DELAY_CHANNEL_B  <= code_reg[1];
            CASCADE_MODE_BIT <= mode_reg;
            OUTPUT_A_PARKED  <= mode_reg;
            DELAY_PS_A       <= ps_a_out;
            DELAY_PS_B       <= ps_b_out;
        end
    end

    // avalon slave: read-only view; one wait cycle then answer
    logic        ack_reg;
    wire         req      = AVS_READ | AVS_WRITE;
    wire         rd_take  = AVS_READ & ~ack_reg;
    logic [31:0] rd_mux;

    always_comb begin
        case (AVS_ADDRESS)
            CSR_CODE_A: rd_mux = {23'h0, code_reg[0]};
            CSR_CODE_B: rd_mux = {23'h0, code_reg[1]};
            CSR_MODE:   rd_mux = {29'h0, state_reg, mode_reg};
            CSR_SHIFT:  rd_mux = {21'h0, shift_reg};
            default:    rd_mux = UNMAPPED_RD;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_reg         <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= '0;
        end else begin
            ack_reg         <= req & ~ack_reg;
            AVS_WAITREQUEST <= ~(req & ~ack_reg);
            if (rd_take)
                AVS_READDATA <= rd_mux;
        end
    end

    other_kept_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (latch_open && !word_chan) |=> $stable(code_reg[1]))
        else $error("channel b changed on a load to a");
    latch_load_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (latch_open && word_chan) |=> code_reg[1] == $past(word_code))
        else $error("channel b missed its load");
    latch_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        !latch_open |=> $stable(code_reg[0]) && $stable(mode_reg))
        else $error("latch changed while closed");
    shift_step_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        sclk_rise |=> shift_reg[WORD_W-2:0] == $past(shift_reg[WORD_W-1:1]))
        else $error("shift register did not advance one bit");
    shift_idle_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        !sclk_rise |=> $stable(shift_reg))
        else $error("shift register moved without serial edge");
    cascade_park_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        mode_reg |=> OUTPUT_A_PARKED && DELAY_PS_A == '0)
        else $error("output a not parked in cascade");
    dual_path_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        !mode_reg |=> DELAY_PS_B == $past(ps_b))
        else $error("channel b delay wrong in dual mode");
    step_ps_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        ##1 ($past(mode_reg) == 1'b0) |->
        DELAY_PS_A == STEP_PS_W'(DELAY_CHANNEL_A) * STEP_PS_W'(STEP_PS))
        else $error("delay not 11 ps per step");
    chan_route_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (latch_open && word_chan) |=> $stable(code_reg[0]))
        else $error("channel a changed on a load to b");

    load_chan_a_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (latch_open && !word_chan) |=> code_reg[0] == $past(word_code))
        else $error("channel a missed its load");

    hold_chan_b_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        !latch_open |=> $stable(code_reg[1]))
        else $error("channel b changed while closed");

    mode_load_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        latch_open |=> mode_reg == $past(word_mode))
        else $error("mode bit missed its load");

    mode_out_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        1'b1 |=> CASCADE_MODE_BIT == $past(mode_reg))
        else $error("mode output lags its latch");

    code_out_a_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        1'b1 |=> DELAY_CHANNEL_A == $past(code_reg[0]))
        else $error("code a output lags its latch");

    code_out_b_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        1'b1 |=> DELAY_CHANNEL_B == $past(code_reg[1]))
        else $error("code b output lags its latch");

    shift_in_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        sclk_rise |=> shift_reg[WORD_W-1] == $past(sdat_next))
        else $error("serial bit not taken at the top");

    park_off_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        !mode_reg |=> !OUTPUT_A_PARKED)
        else $error("output a parked in dual mode");

    cascade_sum_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        mode_reg |=> DELAY_PS_B == $past(STEP_PS_W'(ps_a + ps_b)))
        else $error("cascade delay is not a plus b");

    step_ps_b_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        ##1 ($past(mode_reg) == 1'b0) |->
        DELAY_PS_B == STEP_PS_W'(DELAY_CHANNEL_B) * STEP_PS_W'(STEP_PS))
        else $error("channel b not 11 ps per step");

    // bus answer comes one cycle after a fresh request
    bus_answer_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        ((AVS_READ || AVS_WRITE) && !ack_reg) |=> !AVS_WAITREQUEST)
        else $error("bus request not answered after one wait");

    // bus answer lasts one cycle so a held request is not taken twice
    bus_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");

    // read data stands at the accepting edge
    bus_data_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (AVS_READ && !ack_reg) |=> AVS_READDATA == $past(rd_mux))
        else $error("read data not loaded with the answer");

    // limitation: the cascade view is nominal only; the fixed analog
    // path delay and the enable pin stay outside this block
endmodule // dsc_top
`default_nettype wire

// ===== dv/dsc_host_model.sv
// host controller model driving the three serial load pins
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
    output logic sclk,
    output logic sdat,
    output logic word_load_strobe
);
    logic en_n;
    initial begin
        en_n = 1'b0;
        sclk = 1'b0;
        sdat = 1'b0;
        word_load_strobe = 1'b0;
    end
    task automatic send(input logic [10:0] w, input bit ld, input bit hold);
        en_n = 1'b1;
        for (int i = 0; i < 11; i++) begin
            sdat = w[i];
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        // released line shows the inverse so a stale bit cannot pass
        sdat = ~w[10];
        if (ld) begin
            #16 word_load_strobe = 1'b1;
            #32 word_load_strobe = hold;
        end
        en_n = 1'b0;
    endtask
    task automatic drop;
        word_load_strobe = 1'b0;
    endtask
endmodule // dsc_host_model
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the serial delay configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dsc_pkg::*;
    typedef struct packed {
        logic       ch;
        logic       md;
        logic [8:0] code;
        logic [8:0] ea;
        logic [8:0] eb;
    } dsc_row_t;
    logic        clk, rst_n, sclk, sdat, word_load_strobe, rd, wr, wq, md_o, park;
    logic [1:0]  adr;
    logic [31:0] wd, rdat, d;
    logic [8:0]  ca, cb;
    logic [13:0] pa, pb;
    int          err_count, n_tests;
    dsc_row_t    rows [6];
    dsc_top dut (.REF_CLK(clk), .RESET_N(rst_n), .SERIAL_CLK(sclk),
        .SERIAL_BIT_INPUT(sdat), .WORD_LOAD_STROBE(word_load_strobe),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
        .DELAY_CHANNEL_A(ca), .DELAY_CHANNEL_B(cb),
        .CASCADE_MODE_BIT(md_o), .OUTPUT_A_PARKED(park),
        .DELAY_PS_A(pa), .DELAY_PS_B(pb));
    dsc_host_model host (.sclk(sclk), .sdat(sdat), .word_load_strobe(word_load_strobe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic close_out;
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [1:0] a);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        rd <= ~w;
        wr <= w;
        wd <= 32'hffff_ffff;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 40);
        d = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wq !== 1'b0) begin
            chk("bus wait", 32'h0, 32'(wq));
            close_out();
        end
    endtask
    task automatic check_row(input dsc_row_t x);
        logic [13:0] ea, eb;
        ea = x.md ? 14'h0 : 14'(x.ea * 11);
        eb = x.md ? 14'((x.ea + x.eb) * 11) : 14'(x.eb * 11);
        chk("code a", 32'(x.ea), 32'(ca));
        chk("code b", 32'(x.eb), 32'(cb));
        chk("mode", 32'(x.md), 32'(md_o));
        chk("parked", 32'(x.md), 32'(park));
        chk("ps a", 32'(ea), 32'(pa));
        chk("ps b", 32'(eb), 32'(pb));
        bus(1'b0, 2'h0);
        chk("reg a", 32'(x.ea), d);
        bus(1'b0, 2'h1);
        chk("reg b", 32'(x.eb), d);
        bus(1'b0, 2'h2);
        chk("reg mode", 32'(x.md), 32'(d[0]));
        bus(1'b0, 2'h3);
        chk("reg shift", 32'({x.code, x.md, x.ch}), d);
    endtask
    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 2'h0;
        wd = 32'h0;
        err_count = 0;
        n_tests = 0;
        rows = '{'{1'b0, 1'b0, 9'h001, 9'h001, 9'h000},
                 '{1'b1, 1'b0, 9'h1ff, 9'h001, 9'h1ff},
                 '{1'b0, 1'b0, 9'h1ff, 9'h1ff, 9'h1ff},
                 '{1'b1, 1'b1, 9'h002, 9'h1ff, 9'h002},
                 '{1'b0, 1'b1, 9'h100, 9'h100, 9'h002},
                 '{1'b1, 1'b0, 9'h000, 9'h100, 9'h000}};
        repeat (12) @(posedge clk);
        chk("wait in reset", 32'h1, 32'(wq));
        chk("code a in reset", 32'h0, 32'(ca));
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        foreach (rows[i]) begin
            host.send({rows[i].code, rows[i].md, rows[i].ch}, 1'b1, 1'b0);
            check_row(rows[i]);
        end
        // strobe left open: latch follows a second shifted word
        host.send({9'h0aa, 2'b00}, 1'b1, 1'b1);
        host.send({9'h155, 2'b00}, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        chk("open latch", 32'h155, 32'(ca));
        host.drop();
        host.send({9'h033, 2'b00}, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        chk("closed latch", 32'h155, 32'(ca));
        bus(1'b1, 2'h0);
        bus(1'b0, 2'h0);
        chk("write ignored", 32'h155, d);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("wait in reset", 32'h1, 32'(wq));
        chk("code a in reset", 32'h0, 32'(ca));
        close_out();
    end
endmodule // tb_top
`default_nettype wire
